/* File: dv/fcsm_flash_mdl.sv */
`timescale 1ns/1ps
`default_nettype none

module fcsm_flash_mdl #(
  parameter int unsigned BUSY_CYC = 20,
  parameter logic [15:0] ID_PART  = 16'h00A5  // Arbitrary value.
) (
  input  wire logic        clk,
  input  wire logic [20:0] addr,
  input  wire logic [15:0] dq_i,
  output logic      [15:0] dq_o,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        rp_n
);
  logic [15:0] mem [int];
  logic [63:0] lk    = '0;
  logic [63:0] ld    = '0;
  logic [7:0]  sr    = 8'h00;
  logic [1:0]  mode  = 2'h0;
  logic [1:0]  pend  = 2'h0;
  logic        psusp = 1'b0;
  logic        esusp = 1'b0;
  logic [15:0] rd    = 16'h0000;
  int          pcnt  = 0;
  int          ecnt  = 0;
  logic [7:0]  c;
  logic [5:0]  b, eb;
  logic [1:0]  p;
  logic        sp;
  logic [20:0] pa;
  logic [15:0] pd;
  wire         rd_n  = ce_n | oe_n | !rp_n;
  wire         bsy   = (pcnt > 0 && !psusp) || (ecnt > 0 && !esusp);

  ////////////////////////////////////////////////////////////////////////////
  // A released bus shows the inverse of the last word, never a stale copy.
  assign dq_o = rd_n ? ~rd : rd;

  always @(negedge rd_n) begin
    #1;
    case (mode)
      2'h0: rd = mem.exists(addr) ? mem[addr] : 16'hFFFF;
      2'h1: rd = {8'h00, !bsy, esusp, sr[5:4], 1'b0, psusp, sr[1], 1'b0};
      2'h2: rd = (addr[7:0] == 8'h01) ? ID_PART : {15'h0, lk[addr[20:15]]};
      default: rd = (addr[7:0] == 8'h10) ? 16'h0051 : 16'h0000;
    endcase
  end

  always @(negedge rp_n) begin
    {pcnt, ecnt, psusp, esusp, mode, pend} = '0;
  end

  always @(posedge clk) begin
    if (pcnt > 0 && !psusp) begin
      pcnt--;
      if (pcnt == 0) mem[pa] = pd;
    end else if (ecnt > 0 && !esusp) begin
      ecnt--;
      if (ecnt == 0) foreach (mem[k]) if ((k >> 15) == eb) mem[k] = 16'hFFFF;
    end
  end

  always @(posedge we_n) begin
    if (!ce_n && rp_n) begin
      c = dq_i[7:0];
      b = addr[20:15];
      p = pend;
      sp = psusp | esusp;
      pend = 2'h0;
      if (p == 2'h1) begin
        mode = 2'h1;
        if (c != 8'hD0) sr[5:4] = 2'b11;
        else if (lk[b]) sr[1] = 1'b1;
        else begin
          ecnt = 4 * BUSY_CYC;
          eb = b;
        end
      end else if (p == 2'h2) begin
        mode = 2'h1;
        if (lk[b]) sr[1] = 1'b1;
        else begin
          pa = addr;
          pd = dq_i;
          pcnt = BUSY_CYC;
        end
      end else if (p == 2'h3) begin
        if (c == 8'h01) lk[b] = 1'b1;
        else if (c == 8'h2F) {lk[b], ld[b]} = 2'b11;
        else if (c == 8'hD0 && !ld[b]) lk[b] = 1'b0;
        else if (c != 8'hD0) sr[5:4] = 2'b11;
      end else if (bsy) begin
        if (c == 8'h70) mode = 2'h1;
        if (c == 8'hB0 && pcnt > 0) psusp = 1'b1;
        else if (c == 8'hB0) esusp = 1'b1;
      end else begin
        case (c)
          8'hFF: mode = 2'h0;
          8'h70: mode = 2'h1;
          8'h90: mode = 2'h2;
          8'h98: mode = 2'h3;
          8'h40, 8'h10: pend = 2'h2;
          8'hD0: if (psusp) psusp = 1'b0; else esusp = 1'b0;
          8'h50: if (!sp) {sr, mode} = '0;
          8'h20: if (!sp) pend = 2'h1;
          8'h60: if (!sp || !psusp) pend = 2'h3;
          default: ;
        endcase
      end
    end
  end
endmodule  // fcsm_flash_mdl

`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end

module tb;
  import fcsm_pkg::*;
  logic        hclk      = 1'b0;
  logic        hresetn   = 1'b0;
  logic        hsel      = 1'b0;
  logic        hwrite    = 1'b0;
  logic [1:0]  htrans    = 2'h0;
  logic [2:0]  hsize     = 3'h2;
  logic [31:0] haddr     = 32'h0;
  logic [31:0] hwdata    = 32'h0;
  logic [31:0] hrdata;
  logic        hready;
  logic [20:0] fa;
  logic [15:0] dq_o, dq_m, dq_bus;
  logic        dq_oe, ce_n, oe_n, we_n, rp_n;
  int          checks    = 0;
  int          bad_count = 0;

  assign dq_bus = dq_oe ? dq_o : dq_m;

  fcsm_host fcsm_host_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hready), .hresp(), .flash_addr(fa), .flash_dq_i(dq_bus), .flash_dq_o(dq_o),
    .flash_dq_oe(dq_oe), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
    .flash_reset_powerdown_n(rp_n));

  fcsm_flash_mdl fcsm_flash_mdl_i (
    .clk(hclk), .addr(fa), .dq_i(dq_bus), .dq_o(dq_m), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .rp_n(rp_n));

  ////////////////////////////////////////////////////////////////////////////
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
    hsel <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    ahb(1'b0, a, 32'h0, q);
  endtask

  task automatic op(input fcsm_op_e o, input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    wr(REG_ADDR, a);
    wr(REG_WDATA, d);
    wr(REG_OP, {28'h0, o});
    do rd(REG_STATUS, q); while (q[ST_BUSY_BIT] !== 1'b0);
  endtask

  task automatic done(output logic [31:0] q);
    repeat (40) begin
      op(OP_READ_STAT, 0, 0);
      rd(REG_STATUS, q);
      if (q[ST_RUN_BIT] === 1'b0) break;
    end
  endtask

  task automatic fread(input logic [31:0] a, output logic [31:0] q);
    op(OP_READ, a, 0);
    rd(REG_RDATA, q);
  endtask

  task automatic t_reset();
    logic [31:0] q;
    rd(REG_STATUS, q);
    `CHK("status", 32'h0000_8000, q)
    rd(8'h20, q);
    `CHK("unmapped", 32'h0, q)
    fread(5, q);
    `CHK("array", 16'hFFFF, q[15:0])
    $display("test reset ended");
  endtask

  task automatic t_prog_erase();
    logic [31:0] q;
    op(OP_PROGRAM, 21'h100, 16'h1234);
    op(OP_READ_ID, 0, 0);
    op(OP_PROGRAM, 21'h100, 16'h0000);
    rd(REG_STATUS, q);
    `CHK("refused", 1'b1, q[ST_ERR_BIT])
    wr(REG_STATUS, 32'h2);
    done(q);
    `CHK("ready", 8'h80, q[ST_SR_LSB+:8])
    op(OP_READ_ARRAY, 0, 0);
    fread(21'h100, q);
    `CHK("word", 16'h1234, q[15:0])
    op(OP_ERASE, 21'h104, 0);
    done(q);
    op(OP_READ_ARRAY, 0, 0);
    fread(21'h100, q);
    `CHK("erased", 16'hFFFF, q[15:0])
    $display("test program and erase ended");
  endtask

  task automatic t_bad_seq();
    logic [31:0] q;
    op(OP_RAW, 0, 16'h0020);
    op(OP_RAW, 0, 16'h0077);
    op(OP_READ_STAT, 0, 0);
    rd(REG_STATUS, q);
    `CHK("seq error", 8'hB0, q[ST_SR_LSB+:8])
    op(OP_RAW, 0, 16'h0000);
    rd(REG_STATUS, q);
    `CHK("reserved", 1'b1, q[ST_ERR_BIT])
    wr(REG_STATUS, 32'h2);
    op(OP_CLEAR, 0, 0);
    fread(21'h100, q);
    `CHK("array after clear", 16'hFFFF, q[15:0])
    op(OP_READ_STAT, 0, 0);
    rd(REG_STATUS, q);
    `CHK("cleared", 8'h80, q[ST_SR_LSB+:8])
    $display("test bad sequence ended");
  endtask

  task automatic t_id_query();
    logic [31:0] q;
    op(OP_READ_ID, 1, 0);
    rd(REG_RDATA, q);
    `CHK("part id", 16'h00A5, q[15:0])
    rd(REG_STATUS, q);
    `CHK("id pending", 1'b1, q[ST_IDP_BIT])
    op(OP_READ_ARRAY, 0, 0);
    rd(REG_STATUS, q);
    `CHK("id left", 1'b0, q[ST_IDP_BIT])
    op(OP_QUERY, 21'h10, 0);
    rd(REG_RDATA, q);
    `CHK("query", 16'h0051, q[15:0])
    op(OP_READ_ARRAY, 0, 0);
    $display("test id and query ended");
  endtask

  task automatic t_lock();
    logic [31:0] q;
    op(OP_LOCK, 21'h10000, 0);
    op(OP_PROGRAM, 21'h10000, 16'h0001);
    done(q);
    `CHK("locked", 8'h82, q[ST_SR_LSB+:8])
    op(OP_CLEAR, 0, 0);
    op(OP_LOCKDOWN, 21'h10000, 0);
    op(OP_UNLOCK, 21'h10000, 0);
    op(OP_PROGRAM, 21'h10000, 16'h0001);
    done(q);
    `CHK("held down", 8'h82, q[ST_SR_LSB+:8])
    op(OP_CLEAR, 0, 0);
    op(OP_LOCK, 21'h08000, 0);
    op(OP_UNLOCK, 21'h08000, 0);
    op(OP_PROGRAM, 21'h08000, 16'h0001);
    done(q);
    `CHK("unlocked", 8'h80, q[ST_SR_LSB+:8])
    $display("test lock ended");
  endtask

  task automatic t_suspend();
    logic [31:0] q;
    op(OP_ERASE, 21'h18000, 0);
    op(OP_SUSPEND, 0, 0);
    done(q);
    `CHK("suspended", 8'hC0, q[ST_SR_LSB+:8])
    `CHK("susp flag", 1'b1, q[ST_SUSP_BIT])
    op(OP_PROGRAM, 21'h20000, 16'h5A5A);
    done(q);
    op(OP_READ_ARRAY, 0, 0);
    fread(21'h20000, q);
    `CHK("word in suspend", 16'h5A5A, q[15:0])
    op(OP_RESUME, 0, 0);
    done(q);
    `CHK("resumed", 8'h80, q[ST_SR_LSB+:8])
    op(OP_READ_ARRAY, 0, 0);
    fread(21'h20000, q);
    `CHK("inner word", 16'h5A5A, q[15:0])
    $display("test suspend ended");
  endtask

  task automatic t_abort();
    logic [31:0] q;
    op(OP_PROGRAM, 21'h300, 16'h00AA);
    wr(REG_CTRL, 32'h1);
    repeat (2) @(posedge hclk);
    `CHK("reset pin", 1'b0, rp_n)
    wr(REG_CTRL, 32'h0);
    op(OP_READ_ARRAY, 0, 0);
    fread(21'h300, q);
    `CHK("aborted word", 16'hFFFF, q[15:0])
    $display("test abort ended");
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial forever #50 hclk = ~hclk;

  initial begin
    repeat (30000) @(posedge hclk);
    bad_count++;
    $display("watchdog expired");
    end_of_test();
  end

  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_prog_erase();
    t_bad_seq();
    t_id_query();
    t_lock();
    t_suspend();
    t_abort();
    end_of_test();
  end
endmodule  // tb

`default_nettype wire

/* File: src/fcsm_host.sv */
// Operation
// - Host never writes the reserved command code.
// - Host reads with select and output enable low, write enable high.
// - After identification reads host writes read array to address zero first.
// - Host erases with setup then confirm; only reads, status reads and suspend until done.
// - During program suspend host reads avoid the suspended word; during erase suspend alone, reads and programs avoid the suspended block.
//   The host checks reads against them only while no program runs.
// - During erase suspend host may program another block, then resume.
//
// The AHB-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module fcsm_host
  import fcsm_pkg::*;
#(
  parameter int unsigned ADDR_W    = 21,
  parameter int unsigned BLK_SHIFT = 15
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic              hready,
  input  wire logic [31:0]       hwdata,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic      [ADDR_W-1:0] flash_addr,
  input  wire logic [15:0]       flash_dq_i,
  output logic      [15:0]       flash_dq_o,
  output logic                   flash_dq_oe,
  output logic                   flash_ce_n,
  output logic                   flash_oe_n,
  output logic                   flash_we_n,
  output logic                   flash_reset_powerdown_n
);

  if (ADDR_W > 32 || BLK_SHIFT >= ADDR_W || ADDR_W < 2) begin : g_chk
    $error("fcsm_host: unsupported ADDR_W or BLK_SHIFT");
  end

  function automatic logic [17:0] fcsm_step(input logic [3:0] op, input logic n,
                                            input logic [15:0] wd);
    logic [15:0] c0;
    logic [15:0] c1;
    logic        two;
    logic        rd1;
    c0  = wd;
    c1  = wd;
    two = 1'b1;
    rd1 = 1'b0;
    case (op)
      OP_READ:       begin two = 1'b0; end
      OP_READ_ARRAY: begin c0 = CMD_READ_ARRAY; two = 1'b0; end
      OP_READ_STAT:  begin c0 = CMD_READ_STAT; rd1 = 1'b1; end
      OP_CLEAR:      begin c0 = CMD_CLEAR; two = 1'b0; end
      OP_READ_ID:    begin c0 = CMD_READ_ID; rd1 = 1'b1; end
      OP_QUERY:      begin c0 = CMD_QUERY; rd1 = 1'b1; end
      OP_PROGRAM:    begin c0 = CMD_PROGRAM; end
      OP_ERASE:      begin c0 = CMD_ERASE; c1 = CMD_CONFIRM; end
      OP_SUSPEND:    begin c0 = CMD_SUSPEND; two = 1'b0; end
      OP_RESUME:     begin c0 = CMD_CONFIRM; two = 1'b0; end
      OP_LOCK:       begin c0 = CMD_PROT_SETUP; c1 = CMD_LOCK; end
      OP_UNLOCK:     begin c0 = CMD_PROT_SETUP; c1 = CMD_CONFIRM; end
      OP_LOCKDOWN:   begin c0 = CMD_PROT_SETUP; c1 = CMD_LOCKDOWN; end
      default:       begin two = 1'b0; end
    endcase
    if (!n) begin
      fcsm_step = {!two, op == OP_READ, c0};
    end else begin
      fcsm_step = {1'b1, rd1, c1};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: one wait state, registered read data.

  logic              ap_q, ap_d;
  logic              ap_wr_q, ap_wr_d;
  logic [7:0]        ap_addr_q, ap_addr_d;
  logic              ready_q, ready_d;
  logic [31:0]       hrdata_q, hrdata_d;
  logic [31:0]       rd_mux;
  logic              wr_en;
  logic [ADDR_W-1:0] addr_q;
  logic [15:0]       wdata_q;
  logic [15:0]       rdata_q;
  logic [7:0]        sr_q;
  logic              err_q;
  logic              rp_req_q;
  logic              idp_q;
  logic              prun_q;
  logic              erun_q;
  logic              psus_q;
  logic              esus_q;
  fcsm_state_e       st_q;

  always_comb begin
    ap_d      = hsel && htrans[1] && hready;
    ap_wr_d   = hwrite;
    ap_addr_d = haddr[7:0];
    ready_d   = ap_q || ready_q;
    if (ap_d) begin
      ready_d = 1'b0;
    end
    rd_mux = 32'h0000_0000;
    if (ap_addr_q == REG_ADDR) begin
      rd_mux[ADDR_W-1:0] = addr_q;
    end else if (ap_addr_q == REG_WDATA) begin
      rd_mux[15:0] = wdata_q;
    end else if (ap_addr_q == REG_STATUS) begin
      rd_mux[ST_BUSY_BIT] = st_q != ST_IDLE;
      rd_mux[ST_ERR_BIT]  = err_q;
      rd_mux[ST_RUN_BIT]  = prun_q || erun_q;
      rd_mux[ST_SUSP_BIT] = psus_q || esus_q;
      rd_mux[ST_IDP_BIT]  = idp_q;
      rd_mux[ST_SR_LSB +: 8] = sr_q;
    end else if (ap_addr_q == REG_RDATA) begin
      rd_mux[15:0] = rdata_q;
    end else if (ap_addr_q == REG_CTRL) begin
      rd_mux[CTRL_RP_BIT] = rp_req_q;
    end
    hrdata_d = (ap_q && !ap_wr_q) ? rd_mux : hrdata_q;
    wr_en    = ap_q && ap_wr_q;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q      <= 1'b0;
      ap_wr_q   <= 1'b0;
      ap_addr_q <= 8'h00;
      ready_q   <= 1'b1;
      hrdata_q  <= 32'h0000_0000;
    end else begin
      ap_q      <= ap_d;
      ap_wr_q   <= ap_wr_d;
      ap_addr_q <= ap_addr_d;
      ready_q   <= ready_d;
      hrdata_q  <= hrdata_d;
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = ready_q;
  assign hresp     = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // Command sequencer, pin driver and device state tracking.

  logic [ADDR_W-1:0] addr_d, fa_q, fa_d, eblk_q, eblk_d, pword_q, pword_d;
  logic [15:0]       wdata_d, rdata_d, dqo_q, dqo_d, dq_s1_q, dq_s2_q;
  logic [7:0]        sr_d;
  logic [3:0]        op_q, op_d, cnt_q, cnt_d, new_op;
  logic              step_q, step_d, zadr_q, zadr_d, err_d, rp_req_d, idp_d;
  logic              prun_d, erun_d, psus_d, esus_d, sreq_q, sreq_d;
  logic              dqoe_q, dqoe_d, ce_q, ce_d, oe_q, oe_d, we_q, we_d, rp_q, rp_d;
  logic              ok, run, same_blk, same_word, launch, cap;
  logic [17:0]       stp;
  fcsm_state_e       st_d;

  always_comb begin
    addr_d = addr_q; wdata_d = wdata_q; rdata_d = rdata_q; sr_d = sr_q;
    op_d = op_q; cnt_d = cnt_q; step_d = step_q; zadr_d = zadr_q; err_d = err_q;
    rp_req_d = rp_req_q; idp_d = idp_q; prun_d = prun_q; erun_d = erun_q;
    psus_d = psus_q; esus_d = esus_q; sreq_d = sreq_q; eblk_d = eblk_q;
    pword_d = pword_q; fa_d = fa_q; dqo_d = dqo_q; dqoe_d = dqoe_q; st_d = st_q;
    ce_d = ce_q; oe_d = oe_q; we_d = we_q;
    rp_d = !rp_req_q;
    new_op    = hwdata[3:0];
    run       = prun_q || erun_q;
    same_blk  = addr_q[ADDR_W-1:BLK_SHIFT] == eblk_q[ADDR_W-1:BLK_SHIFT];
    same_word = addr_q == pword_q;
    stp       = fcsm_step(op_q, step_q, wdata_q);
    cap       = 1'b0;
    if (idp_q) begin
      ok = new_op == OP_READ || new_op == OP_READ_ARRAY || new_op == OP_READ_ID;
    end else if (run) begin
      ok = new_op == OP_READ || new_op == OP_READ_STAT || new_op == OP_SUSPEND;
    end else if (psus_q) begin
      ok = (new_op == OP_READ && !same_word) || new_op == OP_READ_ARRAY ||
           new_op == OP_READ_STAT || new_op == OP_READ_ID || new_op == OP_QUERY ||
           new_op == OP_PROGRAM || new_op == OP_RESUME;
    end else if (esus_q) begin
      ok = ((new_op == OP_READ || new_op == OP_PROGRAM) && !same_blk) ||
           new_op == OP_READ_ARRAY || new_op == OP_READ_STAT || new_op == OP_READ_ID ||
           new_op == OP_QUERY || new_op == OP_RESUME || new_op == OP_LOCK ||
           new_op == OP_UNLOCK || new_op == OP_LOCKDOWN;
    end else begin
      ok = new_op != OP_SUSPEND && new_op != OP_RESUME && new_op <= OP_RAW;
    end
    if (new_op == OP_RAW && wdata_q == CMD_RESERVED) begin
      ok = 1'b0;
    end
    launch = wr_en && ap_addr_q == REG_OP && st_q == ST_IDLE && !rp_req_q;
    if (wr_en && ap_addr_q == REG_ADDR) begin
      addr_d = hwdata[ADDR_W-1:0];
    end else if (wr_en && ap_addr_q == REG_WDATA) begin
      wdata_d = hwdata[15:0];
    end else if (wr_en && ap_addr_q == REG_CTRL) begin
      rp_req_d = hwdata[CTRL_RP_BIT];
    end else if (wr_en && ap_addr_q == REG_STATUS && hwdata[ST_ERR_BIT]) begin
      err_d = 1'b0;
    end
    if (wr_en && ap_addr_q == REG_OP && (!launch || !ok)) begin
      err_d = 1'b1;
    end
    if (launch && ok) begin
      op_d = new_op; step_d = 1'b0; zadr_d = idp_q && new_op == OP_READ_ARRAY;
      st_d = ST_SETUP;
      case (new_op)
        OP_READ_ARRAY: idp_d = 1'b0;
        OP_READ_ID:    idp_d = 1'b1;
        OP_PROGRAM:    begin prun_d = 1'b1; pword_d = addr_q; end
        OP_ERASE:      begin erun_d = 1'b1; eblk_d = addr_q; end
        OP_SUSPEND:    sreq_d = 1'b1;
        OP_RESUME:     begin
          if (psus_q) begin
            psus_d = 1'b0; prun_d = 1'b1;
          end else begin
            esus_d = 1'b0; erun_d = 1'b1;
          end
        end
        default: ;
      endcase
    end
    case (st_q)
      ST_SETUP: begin
        fa_d   = (zadr_q || (op_q == OP_READ_ID && !step_q)) ? '0 : addr_q;
        dqo_d  = stp[15:0];
        dqoe_d = !stp[16];
        ce_d   = 1'b0;
        oe_d   = !stp[16];
        we_d   = stp[16];
        cnt_d  = stp[16] ? RD_CYC : WR_CYC;
        st_d   = ST_PULSE;
      end
      ST_PULSE: begin
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h1) begin
          oe_d = 1'b1; we_d = 1'b1; cnt_d = REC_CYC; st_d = ST_HOLD;
          if (oe_q == 1'b0) begin
            rdata_d = dq_s2_q;
            cap = op_q == OP_READ_STAT || run;
          end
        end
      end
      ST_HOLD: begin
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h1) begin
          ce_d = 1'b1; dqoe_d = 1'b0; step_d = 1'b1;
          st_d = stp[17] ? ST_IDLE : ST_SETUP;
        end
      end
      default: ;
    endcase
    if (cap) begin
      sr_d = dq_s2_q[7:0];
      if (dq_s2_q[SR_READY_BIT]) begin
        psus_d = psus_q || (sreq_q && prun_q);
        esus_d = esus_q || (sreq_q && erun_q && !prun_q);
        prun_d = 1'b0; erun_d = 1'b0; sreq_d = 1'b0;
      end
    end
    if (rp_req_q) begin
      prun_d = 1'b0; erun_d = 1'b0; psus_d = 1'b0; esus_d = 1'b0; sreq_d = 1'b0;
      idp_d = 1'b0; st_d = ST_IDLE; ce_d = 1'b1; oe_d = 1'b1; we_d = 1'b1; dqoe_d = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q <= '0; wdata_q <= 16'h0000; rdata_q <= RDATA_RST; sr_q <= SR_RST;
      op_q <= 4'h0; cnt_q <= 4'h0; step_q <= 1'b0; zadr_q <= 1'b0; err_q <= 1'b0;
      rp_req_q <= 1'b0; idp_q <= 1'b0; prun_q <= 1'b0; erun_q <= 1'b0;
      psus_q <= 1'b0; esus_q <= 1'b0; sreq_q <= 1'b0; eblk_q <= '0; pword_q <= '0;
      fa_q <= '0; dqo_q <= 16'h0000; dqoe_q <= 1'b0; st_q <= ST_IDLE;
      ce_q <= 1'b1; oe_q <= 1'b1; we_q <= 1'b1; rp_q <= 1'b0;
      dq_s1_q <= 16'h0000; dq_s2_q <= 16'h0000;
    end else begin
      addr_q <= addr_d; wdata_q <= wdata_d; rdata_q <= rdata_d; sr_q <= sr_d;
      op_q <= op_d; cnt_q <= cnt_d; step_q <= step_d; zadr_q <= zadr_d; err_q <= err_d;
      rp_req_q <= rp_req_d; idp_q <= idp_d; prun_q <= prun_d; erun_q <= erun_d;
      psus_q <= psus_d; esus_q <= esus_d; sreq_q <= sreq_d; eblk_q <= eblk_d;
      pword_q <= pword_d; fa_q <= fa_d; dqo_q <= dqo_d; dqoe_q <= dqoe_d; st_q <= st_d;
      ce_q <= ce_d; oe_q <= oe_d; we_q <= we_d; rp_q <= rp_d;
      dq_s1_q <= flash_dq_i; dq_s2_q <= dq_s1_q;
    end
  end

  assign flash_addr              = fa_q;
  assign flash_dq_o              = dqo_q;
  assign flash_dq_oe             = dqoe_q;
  assign flash_ce_n              = ce_q;
  assign flash_oe_n              = oe_q;
  assign flash_we_n              = we_q;
  assign flash_reset_powerdown_n = rp_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions and covers.

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_READ_PINS: assert property (!oe_q |-> !ce_q && we_q && rp_q && !dqoe_q)
    else $error("read strobe without select, with write or with drive");
  AST_WRITE_PINS: assert property (!we_q |-> !ce_q && oe_q && dqoe_q)
    else $error("write strobe without select or data drive");
  AST_NO_RESERVED: assert property ($fell(we_q) && op_q == OP_RAW |-> dqo_q != CMD_RESERVED)
    else $error("reserved command code written");
  AST_ID_AT_ZERO: assert property ($fell(we_q) && dqo_q == CMD_READ_ID |-> fa_q == '0)
    else $error("identification command not sent to address zero");
  AST_ERASE_PAIR: assert property ($fell(we_q) && op_q == OP_ERASE && dqo_q == CMD_ERASE
                                   |-> ##[2:12] ($fell(we_q) && dqo_q == CMD_CONFIRM))
    else $error("erase setup not followed by confirm");
  AST_RUN_REFUSE: assert property (wr_en && ap_addr_q == REG_OP && launch && run &&
                                   hwdata[3:0] == OP_PROGRAM |=> err_q && st_q == ST_IDLE)
    else $error("program accepted while device busy");
  AST_RESET_ABORT: assert property (rp_req_q |=> !prun_q && !erun_q && !flash_reset_powerdown_n)
    else $error("reset request did not abort the operation");
  AST_SUSP_BLOCK: assert property ($fell(oe_q) && op_q == OP_READ && esus_q
                                   |-> fa_q[ADDR_W-1:BLK_SHIFT] != eblk_q[ADDR_W-1:BLK_SHIFT])
    else $error("read of erase-suspended block");
  AST_STATUS_READY: assert property (cap && !dq_s2_q[SR_READY_BIT] |=> $stable(prun_q) &&
                                     $stable(erun_q))
    else $error("busy status ended an operation");
  AST_LOCK_PAIR: assert property ($fell(we_q) && dqo_q == CMD_PROT_SETUP |-> ##[2:12]
                                  ($fell(we_q) && (dqo_q == CMD_LOCK || dqo_q == CMD_CONFIRM ||
                                                   dqo_q == CMD_LOCKDOWN)))
    else $error("protection setup without second cycle");

  COV_ERASE_SUSP: cover property (esus_q && launch && ok && new_op == OP_PROGRAM);
  COV_PROG_DONE: cover property (cap && prun_q && dq_s2_q[SR_READY_BIT]);
  COV_REFUSED: cover property (wr_en && ap_addr_q == REG_OP && !ok);
  COV_RESUME: cover property (launch && ok && new_op == OP_RESUME);

endmodule // fcsm_host

`default_nettype wire

/* File: src/fcsm_pkg.sv */
package fcsm_pkg;

  // Register byte offsets on the AHB-Lite slave.
  localparam logic [7:0] REG_ADDR   = 8'h00;
  localparam logic [7:0] REG_WDATA  = 8'h04;
  localparam logic [7:0] REG_OP     = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA  = 8'h10;
  localparam logic [7:0] REG_CTRL   = 8'h14;

  // Status and control register field positions.
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_ERR_BIT  = 1;
  localparam int unsigned ST_RUN_BIT  = 2;
  localparam int unsigned ST_SUSP_BIT = 3;
  localparam int unsigned ST_IDP_BIT  = 4;
  localparam int unsigned ST_SR_LSB   = 8;
  localparam int unsigned CTRL_RP_BIT = 0;
  localparam int unsigned SR_READY_BIT = 7;

  // Reset values.
  localparam logic [15:0] RDATA_RST = 16'h0000;
  localparam logic [7:0]  SR_RST    = 8'h80;

  // Flash command codes.
  localparam logic [15:0] CMD_READ_ARRAY = 16'h00FF;
  localparam logic [15:0] CMD_READ_STAT  = 16'h0070;
  localparam logic [15:0] CMD_CLEAR      = 16'h0050;
  localparam logic [15:0] CMD_READ_ID    = 16'h0090;
  localparam logic [15:0] CMD_QUERY      = 16'h0098;
  localparam logic [15:0] CMD_PROGRAM    = 16'h0040;
  localparam logic [15:0] CMD_ERASE      = 16'h0020;
  localparam logic [15:0] CMD_CONFIRM    = 16'h00D0;
  localparam logic [15:0] CMD_SUSPEND    = 16'h00B0;
  localparam logic [15:0] CMD_PROT_SETUP = 16'h0060;
  localparam logic [15:0] CMD_LOCK       = 16'h0001;
  localparam logic [15:0] CMD_LOCKDOWN   = 16'h002F;
  localparam logic [15:0] CMD_RESERVED   = 16'h0000;

  // Host operations written to the operation register.
  typedef enum logic [3:0] {
    OP_READ = 4'h0, OP_READ_ARRAY = 4'h1, OP_READ_STAT = 4'h2, OP_CLEAR = 4'h3,
    OP_READ_ID = 4'h4, OP_QUERY = 4'h5, OP_PROGRAM = 4'h6, OP_ERASE = 4'h7,
    OP_SUSPEND = 4'h8, OP_RESUME = 4'h9, OP_LOCK = 4'hA, OP_UNLOCK = 4'hB,
    OP_LOCKDOWN = 4'hC, OP_RAW = 4'hD
  } fcsm_op_e;

  // Pin sequencer states.
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_SETUP = 4'b0010,
    ST_PULSE = 4'b0100,
    ST_HOLD  = 4'b1000
  } fcsm_state_e;

  // Pin timing.
  localparam int unsigned CLK_NS      = 100;
  localparam int unsigned T_WR_NS     = 100;
  localparam int unsigned T_ACC_NS    = 110;
  localparam int unsigned T_REC_NS    = 100;
  localparam int unsigned SYNC_STAGES = 2;
  localparam logic [3:0] WR_CYC  = 4'((T_WR_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] RD_CYC  = 4'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES);
  localparam logic [3:0] REC_CYC = 4'((T_REC_NS + CLK_NS - 1) / CLK_NS);

endpackage : fcsm_pkg
